// ---- verilog/pstat_regs.svh ----
// Register address, bit positions and reset values of the PHY status register.
`ifndef PSTAT_REGS_SVH
`define PSTAT_REGS_SVH

// ----------------------------------------------------------------------
// Address and width
// ----------------------------------------------------------------------
`define PSTAT_REG_ADDR 5'h01
`define PSTAT_ADDR_W 5
`define PSTAT_DATA_W 16

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define PSTAT_BIT_T4 15
`define PSTAT_ABIL_HI 14
`define PSTAT_ABIL_LO 11
`define PSTAT_RSV_HI 10
`define PSTAT_RSV_LO 7
`define PSTAT_BIT_NOPRE 6
`define PSTAT_BIT_ANDONE 5
`define PSTAT_BIT_RFAULT 4
`define PSTAT_BIT_ANABIL 3
`define PSTAT_BIT_LINK 2
`define PSTAT_BIT_JABBER 1
`define PSTAT_BIT_EXTCAP 0

// ----------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------
`define PSTAT_T4_VAL 1'b0
`define PSTAT_RSV_VAL 4'h0
`define PSTAT_ANABIL_VAL 1'b1
`define PSTAT_EXTCAP_VAL 1'b1
`define PSTAT_ABIL_RST 4'hf
`define PSTAT_NOPRE_RST 1'b0
`define PSTAT_LH_RST 1'b0
`define PSTAT_LL_RST 1'b0
`define PSTAT_WORD_RST 16'h0000

`endif

// ---- verilog/pstat_pkg.sv ----
// Types shared by the PHY status register modules.
package pstat_pkg;

	// ------------------------------------------------------------------
	// Latch kinds
	// ------------------------------------------------------------------
	typedef enum {
		PSTAT_LATCH_HIGH,
		PSTAT_LATCH_LOW
	} pstat_latch_kind_t;

	// ------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic flag;
	} pstat_latch_state_t;

	typedef struct packed {
		logic [3:0] ability;
		logic no_preamble;
		logic [15:0] rd_data;
		logic rd_valid;
	} pstat_state_t;

endpackage : pstat_pkg

// ---- verilog/pstat_latch_if.sv ----
// Interface between the status register and one latching status flag.
`timescale 1ns/1ps
interface pstat_latch_if;
	logic cond;
	logic rd_clear;
	logic flag;

	modport owner (
		input cond,
		input rd_clear,
		output flag
	);

	modport user (
		output cond,
		output rd_clear,
		input flag
	);
endinterface : pstat_latch_if

// ---- verilog/pstat_latch.sv ----
// One latching status flag, latch-high or latch-low, cleared by a read.
`timescale 1ns/1ps
module pstat_latch #(
	parameter pstat_pkg::pstat_latch_kind_t KIND = pstat_pkg::PSTAT_LATCH_HIGH
) (
	input wire logic clk_sys,
	input wire logic srst,
	pstat_latch_if.owner lif
);
	import pstat_pkg::*;
	`include "pstat_regs.svh"

	pstat_latch_state_t st;
	pstat_latch_state_t next_st;

	// A condition present in the read cycle wins over the read's clear.
	always_comb
	begin
		next_st = st;
		if (KIND == PSTAT_LATCH_HIGH)
		begin
			next_st.flag = lif.cond | (st.flag & ~lif.rd_clear);
		end
		else
		begin
			next_st.flag = lif.cond & (st.flag | lif.rd_clear);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st.flag <= (KIND == PSTAT_LATCH_HIGH) ? `PSTAT_LH_RST : `PSTAT_LL_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign lif.flag = st.flag;

endmodule : pstat_latch

// ---- verilog/pstat_status.sv ----
// PHY status register: abilities, latched link events, management access.
//
// Function
// - The register is 16 bits wide and is read through the management port.
// - Synchronous reset loads every bit with its default value.
// - Bit 15 is read-only and always reads zero.
// - Bits 14 to 11 report the four media abilities and reset to one.
// - Override-writable bits take writes only while override enable is one.
// - Reserved bits 10 to 7 read and reset zero and ignore writes.
// - Bit 6 tells if frames without preamble are taken; resets to zero.
// - Bit 5 latches high on negotiation complete only while negotiation is enabled.
// - Bit 4 latches high on a remote fault reported by the link partner.
// - Bit 0 is read-only and always reads one.
// - Bit 2 latches low on link loss and shows the live link after a read.
// - Bit 1 latches high on jabber while detection is on; a read clears it.
// - A read of the register clears the latched remote fault.
// - Restarting negotiation keeps latched-high bits; a second read is live.
`timescale 1ns/1ps
module pstat_status #(
	parameter int ADDR_W = 5
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [ADDR_W-1:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic override_writable,
	input wire logic an_enable,
	input wire logic an_done,
	input wire logic an_restart,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic jabber_enable,
	input wire logic jabber,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	output logic [3:0] ability,
	output logic frame_no_preamble_ability
);
	import pstat_pkg::*;
	`include "pstat_regs.svh"

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (ADDR_W != `PSTAT_ADDR_W)
	begin : g_bad_addr_w
		$error("pstat_status: ADDR_W must match the management address width");
	end

	if ($bits(mgmt_wdata) != `PSTAT_DATA_W)
	begin : g_bad_wdata_w
		$error("pstat_status: write data must match the register width");
	end

	if ($bits(mgmt_rdata) != `PSTAT_DATA_W)
	begin : g_bad_rdata_w
		$error("pstat_status: read data must match the register width");
	end

	if ($bits(`PSTAT_WORD_RST) != `PSTAT_DATA_W)
	begin : g_bad_word_rst
		$error("pstat_status: word reset value must match the register width");
	end

	if (`PSTAT_ABIL_HI - `PSTAT_ABIL_LO + 1 != $bits(ability))
	begin : g_bad_abil_w
		$error("pstat_status: ability field must match the ability port");
	end

	if (`PSTAT_RSV_HI - `PSTAT_RSV_LO + 1 != $bits(`PSTAT_RSV_VAL))
	begin : g_bad_rsv_w
		$error("pstat_status: reserved field must match its fixed value");
	end

	// ------------------------------------------------------------------
	// Word assembly
	// ------------------------------------------------------------------
	function automatic logic [15:0] build_word(
		input logic [3:0] abil,
		input logic nopre,
		input logic andone,
		input logic rfault,
		input logic link,
		input logic jab
	);
		logic [15:0] w;
		w = `PSTAT_WORD_RST;
		w[`PSTAT_BIT_T4] = `PSTAT_T4_VAL;
		w[`PSTAT_ABIL_HI:`PSTAT_ABIL_LO] = abil;
		w[`PSTAT_RSV_HI:`PSTAT_RSV_LO] = `PSTAT_RSV_VAL;
		w[`PSTAT_BIT_NOPRE] = nopre;
		w[`PSTAT_BIT_ANDONE] = andone;
		w[`PSTAT_BIT_RFAULT] = rfault;
		w[`PSTAT_BIT_ANABIL] = `PSTAT_ANABIL_VAL;
		w[`PSTAT_BIT_LINK] = link;
		w[`PSTAT_BIT_JABBER] = jab;
		w[`PSTAT_BIT_EXTCAP] = `PSTAT_EXTCAP_VAL;
		return w;
	endfunction : build_word

	// ------------------------------------------------------------------
	// Address decode and field update
	// ------------------------------------------------------------------
	function automatic logic addr_match(input logic [ADDR_W-1:0] a);
		return a == `PSTAT_REG_ADDR;
	endfunction : addr_match

	// Reserved bits are not stored, so only these fields take a write.
	function automatic pstat_state_t take_override(
		input pstat_state_t cur,
		input logic [15:0] wdata
	);
		pstat_state_t upd;
		upd = cur;
		upd.ability = wdata[`PSTAT_ABIL_HI:`PSTAT_ABIL_LO];
		upd.no_preamble = wdata[`PSTAT_BIT_NOPRE];
		return upd;
	endfunction : take_override

	// ------------------------------------------------------------------
	// Latching flags
	// ------------------------------------------------------------------
	pstat_latch_if andone_if();
	pstat_latch_if rfault_if();
	pstat_latch_if link_if();
	pstat_latch_if jab_if();

	logic hit;
	logic rd_hit;
	logic wr_hit;

	assign hit = addr_match(mgmt_addr);
	assign rd_hit = mgmt_rd & hit;
	assign wr_hit = mgmt_wr & hit;

	// Negotiation restart is deliberately not a clear term.
	assign andone_if.cond = an_enable & an_done;
	assign andone_if.rd_clear = rd_hit;
	assign rfault_if.cond = remote_fault;
	assign rfault_if.rd_clear = rd_hit;
	assign link_if.cond = link_up;
	assign link_if.rd_clear = rd_hit;
	assign jab_if.cond = jabber_enable & jabber;
	assign jab_if.rd_clear = rd_hit;

	pstat_latch #(
		.KIND(PSTAT_LATCH_HIGH)
	) u_andone (
		.clk_sys(clk_sys),
		.srst(srst),
		.lif(andone_if.owner)
	);

	pstat_latch #(
		.KIND(PSTAT_LATCH_HIGH)
	) u_rfault (
		.clk_sys(clk_sys),
		.srst(srst),
		.lif(rfault_if.owner)
	);

	pstat_latch #(
		.KIND(PSTAT_LATCH_LOW)
	) u_link (
		.clk_sys(clk_sys),
		.srst(srst),
		.lif(link_if.owner)
	);

	pstat_latch #(
		.KIND(PSTAT_LATCH_HIGH)
	) u_jab (
		.clk_sys(clk_sys),
		.srst(srst),
		.lif(jab_if.owner)
	);

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	pstat_state_t st;
	pstat_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.rd_valid = rd_hit;
		if (rd_hit)
		begin
			// Captured before the latches clear at this same edge.
			next_st.rd_data = build_word(st.ability, st.no_preamble,
				andone_if.flag, rfault_if.flag, link_if.flag, jab_if.flag);
		end
		// Only override-writable fields are stored; the rest ignore writes.
		if (wr_hit && override_writable)
		begin
			next_st = take_override(next_st, mgmt_wdata);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st.ability <= `PSTAT_ABIL_RST;
			st.no_preamble <= `PSTAT_NOPRE_RST;
			st.rd_data <= `PSTAT_WORD_RST;
			st.rd_valid <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign mgmt_rdata = st.rd_data;
	assign mgmt_rvalid = st.rd_valid;
	assign ability = st.ability;
	assign frame_no_preamble_ability = st.no_preamble;

endmodule : pstat_status

// ---- testbench/pstat_status_asserts.sv ----
// Port assertions for the PHY status register.
`timescale 1ns/1ps
module pstat_status_asserts #(
	parameter int ADDR_W = 5
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [ADDR_W-1:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic override_writable,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic jabber_enable,
	input wire logic jabber,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic [3:0] ability,
	input wire logic frame_no_preamble_ability
);
	wire rd1 = mgmt_rd && mgmt_addr == 5'h01;
	wire [4:0] cur = {ability, frame_no_preamble_ability};
	wire [4:0] wrf = {mgmt_wdata[14:11], mgmt_wdata[6]};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	rvalid_read_a: assert property (rd1 |=> mgmt_rvalid)
		else $error("read not answered");
	rvalid_only_a: assert property (!rd1 |=> !mgmt_rvalid)
		else $error("answer without read");
	reset_vals_a: assert property ($past(srst) |-> cur == 5'h1e &&
		mgmt_rdata == 16'h0000) else $error("bad reset values");
	fixed_bits_a: assert property (mgmt_rvalid |->
		(mgmt_rdata & 16'h8789) == 16'h0009) else $error("fixed bits");
	rd_fields_a: assert property (mgmt_rvalid |->
		{mgmt_rdata[14:11], mgmt_rdata[6]} == $past(cur))
		else $error("read fields differ");
	wr_locked_a: assert property (mgmt_wr && !override_writable |=>
		$stable(cur)) else $error("locked write taken");
	wr_taken_a: assert property (mgmt_wr && override_writable &&
		mgmt_addr == 5'h01 |=> cur == $past(wrf)) else $error("write lost");
	jab_latch_a: assert property (jabber_enable && jabber ##1 rd1
		|=> mgmt_rdata[1]) else $error("jabber not latched");
	rf_clear_a: assert property (rd1 && !remote_fault ##1
		!remote_fault ##1 rd1 |=> !mgmt_rdata[4]) else $error("fault kept");
	link_low_a: assert property (!link_up ##1 rd1 |=>
		!mgmt_rdata[2]) else $error("link loss not shown");
endmodule : pstat_status_asserts
bind pstat_status pstat_status_asserts #(.ADDR_W(ADDR_W)) i_chk (.*);

// ---- testbench/pstat_station.sv ----
// Management station model issuing single-cycle register accesses.
`timescale 1ns/1ps
module pstat_station (
	input wire logic clk_sys,
	output logic mgmt_rd,
	output logic mgmt_wr,
	output logic [4:0] mgmt_addr,
	output logic [15:0] mgmt_wdata
);
	initial
		{mgmt_rd, mgmt_wr, mgmt_addr, mgmt_wdata} = '0;
	task xfer(input logic r, input logic w, input logic [4:0] a,
		input logic [15:0] d);
		@(negedge clk_sys);
		mgmt_rd = r;
		mgmt_wr = w;
		mgmt_addr = a;
		mgmt_wdata = d & 16'hf87f;
		@(negedge clk_sys);
		{mgmt_rd, mgmt_wr} = 2'h0;
		mgmt_addr = ~a;
		mgmt_wdata = ~mgmt_wdata;
	endtask : xfer
endmodule : pstat_station

// ---- testbench/phy_status_register_test.sv ----
// Self-checking bench for the PHY status register.
`timescale 1ns/1ps
module phy_status_register_test;
	logic clk_sys, srst, mgmt_rd, mgmt_wr, mgmt_rvalid, frame_no_preamble_ability;
	logic override_writable, an_enable, an_done, an_restart, remote_fault;
	logic link_up, jabber_enable, jabber, pend;
	logic [4:0] mgmt_addr;
	logic [3:0] ability;
	logic [15:0] mgmt_wdata, mgmt_rdata, exp_w;
	int bad_count, comparisons, cyc, m_ab, m_np, f_an, f_rf, f_ln, f_jb;
	pstat_status i_dut (.*);
	pstat_station i_sta (.*);
	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task set_st(input logic [7:0] v);
		{override_writable, an_enable, an_done, an_restart, remote_fault,
			link_up, jabber_enable, jabber} = v;
	endtask : set_st
	task test_done;
		$display("compared %0d, failed %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// ------------------------------------------------------------------
	// Reference model, compared before each edge updates the outputs.
	// ------------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!srst)
		begin
			chk(16'(mgmt_rvalid), 16'(pend));
			chk(mgmt_rdata, exp_w);
			chk(16'({ability, frame_no_preamble_ability}),
				16'({4'(m_ab), 1'(m_np)}));
		end
		if (srst)
			{m_ab, m_np, f_an, f_rf, f_ln, f_jb, pend, exp_w} = {32'd15, 160'd0, 17'h0};
		else
		begin
			pend = mgmt_rd && mgmt_addr == 5'h01;
			if (pend)
				exp_w = {5'(m_ab), 4'h0, 1'(m_np), 1'(f_an), 1'(f_rf),
					1'h1, 1'(f_ln), 1'(f_jb), 1'h1};
			if (mgmt_wr && mgmt_addr == 5'h01 && override_writable)
				{m_ab, m_np} = {28'h0, mgmt_wdata[14:11], 31'h0, mgmt_wdata[6]};
			f_an = (an_enable && an_done) || (f_an && !pend);
			f_rf = remote_fault || (f_rf && !pend);
			f_jb = (jabber_enable && jabber) || (f_jb && !pend);
			f_ln = link_up && (f_ln || pend);
		end
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 2500)
		begin
			bad_count++;
			test_done();
		end
	end
	initial
	begin
		set_st(8'h00);
		srst = 1'h1;
		repeat (10) @(negedge clk_sys);
		srst = 1'h0;
		void'($urandom(43576));
		i_sta.xfer(1'h1, 1'h0, 5'h01, 16'h0000);
		i_sta.xfer(1'h0, 1'h1, 5'h01, 16'h0000);
		set_st(8'h80);
		i_sta.xfer(1'h0, 1'h1, 5'h02, 16'h0000);
		i_sta.xfer(1'h1, 1'h1, 5'h01, 16'h5040);
		$display("test defaults and override done");
		set_st(8'h0f);
		i_sta.xfer(1'h1, 1'h0, 5'h01, 16'h0000);
		set_st(8'h10);
		repeat (2) i_sta.xfer(1'h1, 1'h0, 5'h01, 16'h0000);
		$display("test latches done");
		repeat (400)
		begin
			set_st(8'($urandom));
			i_sta.xfer(1'($urandom), 1'($urandom), 5'($urandom & 1), 16'($urandom));
		end
		$display("test random traffic done");
		srst = 1'h1;
		@(negedge clk_sys);
		srst = 1'h0;
		i_sta.xfer(1'h1, 1'h0, 5'h01, 16'h0000);
		$display("test mid-run reset done");
		test_done();
	end
endmodule : phy_status_register_test
